// ==== core/hbpwm_pkg.sv ====
package hbpwm_pkg;

  localparam int          NUM_BRIDGES  = 3;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_MODE    = 8'h04;
  localparam logic [7:0]  ADDR_TIME0   = 8'h10;
  localparam logic [7:0]  ADDR_PCHG0   = 8'h20;
  localparam logic [7:0]  ADDR_STAT0   = 8'h30;

  localparam int          CTRL_SEL_BIT  = 0;
  localparam int          CTRL_DET_BIT  = 1;
  localparam int          CTRL_TMOD_BIT = 2;
  localparam int          CTRL_AGC_MSB  = 4;
  localparam int          CFG_WIDTH     = 4;

  localparam logic [4:0]  CTRL_RST     = 5'h00;
  localparam logic [11:0] MODE_RST     = 12'h000;
  localparam logic [23:0] TIME_RST     = 24'h201010;
  localparam logic [21:0] PCHG_RST     = 22'h200808;
  localparam logic [5:0]  CUR_MIN      = 6'h01;
  localparam logic [5:0]  CUR_INIT     = 6'h08;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MODE_PASSIVE_OFF = 2'h0,
    MODE_LS_PWM      = 2'h1,
    MODE_HS_PWM      = 2'h2,
    MODE_ACTIVE_OFF  = 2'h3
  } hbpwm_mode_e;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h1,
    MS_ON   = 3'h2,
    MS_OFF  = 3'h4
  } hbpwm_meas_e;

  typedef struct packed {
    logic        active_freewheel_en;
    logic        bridge_pwm_enable;
    hbpwm_mode_e bridge_mode;
  } hbpwm_cfg_s;

endpackage : hbpwm_pkg

// ==== core/hbpwm_top.sv ====
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module hbpwm_top
  import hbpwm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   pwm_in_a,
  input  wire logic                   pwm_in_c,
  input  wire logic                   pwm_in_e,
  input  wire logic [NUM_BRIDGES-1:0] sw_start,
  input  wire logic [NUM_BRIDGES-1:0] sw_done,
  input  wire logic [NUM_BRIDGES-1:0] pwm_fet_active,
  output logic [NUM_BRIDGES-1:0]      high_side_fet,
  output logic [NUM_BRIDGES-1:0]      low_side_fet,
  output logic [NUM_BRIDGES-1:0]      hold_off_active,
  output logic [3*6-1:0]              gate_current
);

  function automatic logic [31:0] hbpwm_merge(input logic [31:0] o, input logic [31:0] n,
                                              input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8+:8] = n[i*8+:8];
    end
    return r;
  endfunction : hbpwm_merge

  // per-bridge word at base + 4*b, b = 0..2
  function automatic logic hbpwm_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:4] == base[7:4] && a[3:2] != 2'h3 && a[1:0] == 2'h0;
  endfunction : hbpwm_hit

  function automatic logic [5:0] hbpwm_adapt(input logic [5:0] l, input logic up,
                                             input logic [5:0] mx);
    logic [5:0] r;
    r = l;
    if (up && l < mx)
      r = l + 6'h01;
    else if (!up && l > CUR_MIN)
      r = l - 6'h01;
    if (r > mx)
      r = mx;
    if (r < CUR_MIN)
      r = CUR_MIN;
    return r;
  endfunction : hbpwm_adapt

  logic [11:0] sy1_r;
  logic [11:0] sy2_r;
  logic [4:0]  ctrl_r;
  logic [11:0] mode_r;
  logic [23:0] time_r [NUM_BRIDGES];
  logic [21:0] pchg_r [NUM_BRIDGES];
  logic [31:0] stat_r [NUM_BRIDGES];
  logic        hs_r   [NUM_BRIDGES];
  logic        ls_r   [NUM_BRIDGES];
  logic        hold_r [NUM_BRIDGES];
  logic [5:0]  cur_r  [NUM_BRIDGES];
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sy1_r <= 12'h000;
      sy2_r <= 12'h000;
    end
    else
    begin
      sy1_r <= {pwm_fet_active, sw_done, sw_start, pwm_in_e, pwm_in_c, pwm_in_a};
      sy2_r <= sy1_r;
    end
  end

  wire        sel_six = ctrl_r[CTRL_SEL_BIT];
  wire        det_en  = ctrl_r[CTRL_DET_BIT];
  wire        tmod_en = ctrl_r[CTRL_TMOD_BIT];
  wire        adapt_en = ctrl_r[CTRL_AGC_MSB];
  wire [1:0]  wi      = s_axi_awaddr[3:2];
  wire [1:0]  ri      = s_axi_araddr[3:2];
  wire        wa_ctrl = s_axi_awaddr == ADDR_CTRL;
  wire        wa_mode = s_axi_awaddr == ADDR_MODE;
  wire        wa_time = hbpwm_hit(s_axi_awaddr, ADDR_TIME0);
  wire        wa_pchg = hbpwm_hit(s_axi_awaddr, ADDR_PCHG0);
  wire        wa_stat = hbpwm_hit(s_axi_awaddr, ADDR_STAT0);
  wire        wr_hit  = wa_ctrl | wa_mode | wa_time | wa_pchg | wa_stat;
  wire        ra_ctrl = s_axi_araddr == ADDR_CTRL;
  wire        ra_mode = s_axi_araddr == ADDR_MODE;
  wire        ra_time = hbpwm_hit(s_axi_araddr, ADDR_TIME0);
  wire        ra_pchg = hbpwm_hit(s_axi_araddr, ADDR_PCHG0);
  wire        ra_stat = hbpwm_hit(s_axi_araddr, ADDR_STAT0);
  wire        rd_hit  = ra_ctrl | ra_mode | ra_time | ra_pchg | ra_stat;
  // both channels taken together keeps the slave simple
  wire        wr_go   = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
  wire        rd_go   = s_axi_arvalid & ~arready_r & ~rvalid_r;
  wire [31:0] wmerge  = hbpwm_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
  wire [31:0] rd_dat  = ra_ctrl ? {27'h0000000, ctrl_r} :
                        ra_mode ? {20'h00000, mode_r} :
                        ra_time ? {8'h00, time_r[ri]} :
                        ra_pchg ? {10'h000, pchg_r[ri]} :
                        ra_stat ? stat_r[ri] : 32'h0000_0000;
  wire [31:0] ctrl_m  = hbpwm_merge({27'h0000000, ctrl_r}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] mode_m  = hbpwm_merge({20'h00000, mode_r}, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      arready_r <= rd_go;
      if (rd_go)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_dat;
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // status words are read-only; writes to them are dropped
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r <= CTRL_RST;
      mode_r <= MODE_RST;
    end
    else if (wr_go)
    begin
      if (wa_ctrl)
        ctrl_r <= ctrl_m[4:0];
      if (wa_mode)
        mode_r <= mode_m[11:0];
    end
  end

  genvar b;
  generate
    for (b = 0; b < NUM_BRIDGES; b++)
    begin : g_br
      hbpwm_cfg_s  cfg;
      hbpwm_meas_e ms_r;
      logic        pq_r;
      logic        shon_r;
      logic        shoff_r;
      logic        seen_r;
      logic        phk_r;
      logic        stl_r;
      logic        dnl_r;
      logic [7:0]  cnt_r;
      logic [7:0]  dt_r;
      logic [7:0]  ph_r;
      logic [7:0]  mc_r;
      logic [7:0]  t1_r;
      logic [5:0]  p1_r;
      logic [5:0]  p2_r;
      logic [5:0]  d1_r;
      logic [5:0]  d2_r;

      assign cfg = mode_r[b*CFG_WIDTH+:CFG_WIDTH];
      wire       pwm   = sy2_r[b];
      // levels left over from the last switching count only once seen low
      wire       st_raw = sy2_r[3+b];
      wire       dn_raw = sy2_r[6+b];
      wire       st    = st_raw & stl_r;
      wire       dn    = dn_raw & dnl_r;
      wire       dir   = sy2_r[9+b];
      wire [7:0] fw_w  = time_r[b][7:0];
      wire [7:0] act_w = time_r[b][15:8];
      wire [7:0] blk_w = time_r[b][23:16];
      wire [7:0] pd    = pchg_r[b][7:0];
      wire [7:0] pdd   = pchg_r[b][15:8];
      wire [5:0] mx    = pchg_r[b][21:16];
      wire       re    = pwm & ~pq_r;
      wire       fe    = ~pwm & pq_r;
      wire       shrt  = shon_r | shoff_r;
      wire       act   = ~det_en | shrt | dir;
      wire       afw_e = cfg.active_freewheel_en & ~shrt;
      wire       run   = cfg.bridge_pwm_enable & ~sel_six &
                         (cfg.bridge_mode == MODE_LS_PWM || cfg.bridge_mode == MODE_HS_PWM);
      wire       quiet = dt_r == 8'h00 && !re && !fe;
      wire       pf    = run & pwm & quiet;
      wire       of    = run & ~pwm & afw_e & quiet;
      wire       hs_n  = (cfg.bridge_mode == MODE_HS_PWM) ? pf : of;
      wire       ls_n  = (cfg.bridge_mode == MODE_LS_PWM) ? pf : of;
      wire       frst  = ph_r > ((phk_r ? pd : pdd) >> 1);
      wire       half2 = tmod_en & ~frst;
      wire [5:0] cur_n = (ph_r == 8'h00) ? 6'h00 :
                         phk_r ? (half2 ? p2_r : p1_r) : (half2 ? d2_r : d1_r);
      // measured fet is the active one; with detection off that is the pwm fet
      wire       on_ev = run & (act ? re : fe);
      wire       of_ev = run & (act ? fe : re);
      wire       lim   = mc_r >= ((ms_r == MS_ON) ? blk_w : act_w);
      wire       fin   = (ms_r != MS_IDLE) & (dn | lim);
      wire [7:0] tdel  = (seen_r | st) ? t1_r : 8'h00;
      wire [7:0] tsw   = dn ? mc_r - t1_r : 8'h00;
      wire [31:0] time_m = hbpwm_merge({8'h00, time_r[b]}, s_axi_wdata, s_axi_wstrb);
      wire [31:0] pchg_m = hbpwm_merge({10'h000, pchg_r[b]}, s_axi_wdata, s_axi_wstrb);

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          pq_r    <= 1'b0;
          cnt_r   <= 8'h00;
          shon_r  <= 1'b0;
          shoff_r <= 1'b0;
          dt_r    <= 8'h00;
        end
        else
        begin
          pq_r  <= pwm;
          cnt_r <= (re | fe) ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
          if (fe)
            shon_r <= cnt_r < fw_w;
          if (re)
            shoff_r <= cnt_r < act_w;
          // break before make: opposite fet settles before the next one turns on
          if (re)
            dt_r <= act ? fw_w : act_w;
          else if (fe)
            dt_r <= act ? act_w : fw_w;
          else if (dt_r != 8'h00)
            dt_r <= dt_r - 8'h01;
        end
      end

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          hs_r[b]   <= 1'b0;
          ls_r[b]   <= 1'b0;
          hold_r[b] <= 1'b0;
          cur_r[b]  <= 6'h00;
          ph_r      <= 8'h00;
          phk_r     <= 1'b0;
        end
        else
        begin
          hs_r[b]   <= hs_n;
          ls_r[b]   <= ls_n;
          hold_r[b] <= cfg.bridge_mode == MODE_ACTIVE_OFF;
          cur_r[b]  <= cur_n;
          if (on_ev)
          begin
            ph_r  <= pd;
            phk_r <= 1'b1;
          end
          else if (of_ev)
          begin
            ph_r  <= pdd;
            phk_r <= 1'b0;
          end
          else if (ph_r != 8'h00)
            ph_r <= ph_r - 8'h01;
        end
      end

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          ms_r   <= MS_IDLE;
          mc_r   <= 8'h00;
          t1_r   <= 8'h00;
          seen_r <= 1'b0;
          stl_r  <= 1'b0;
          dnl_r  <= 1'b0;
        end
        else
        begin
          mc_r <= mc_r + {7'h00, mc_r != 8'hFF};
          if (on_ev | of_ev)
          begin
            stl_r <= 1'b0;
            dnl_r <= 1'b0;
          end
          else
          begin
            if (!st_raw)
              stl_r <= 1'b1;
            if (!dn_raw)
              dnl_r <= 1'b1;
          end
          if (st && !seen_r)
          begin
            seen_r <= 1'b1;
            t1_r   <= mc_r;
          end
          case (ms_r)
            MS_IDLE, MS_ON, MS_OFF:
            begin
              if (on_ev | of_ev)
              begin
                ms_r   <= on_ev ? MS_ON : MS_OFF;
                mc_r   <= 8'h00;
                seen_r <= 1'b0;
                t1_r   <= 8'h00;
              end
              else if (fin)
                ms_r <= MS_IDLE;
            end
            default: ms_r <= MS_IDLE;
          endcase
        end
      end

      // a new edge before the end abandons the measurement unreported
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          stat_r[b] <= 32'h0000_0000;
          time_r[b] <= TIME_RST;
          pchg_r[b] <= PCHG_RST;
          p1_r      <= CUR_INIT;
          p2_r      <= CUR_INIT;
          d1_r      <= CUR_INIT;
          d2_r      <= CUR_INIT;
        end
        else
        begin
          if (wr_go && wa_time && wi == 2'(b))
            time_r[b] <= time_m[23:0];
          if (wr_go && wa_pchg && wi == 2'(b))
            pchg_r[b] <= pchg_m[21:0];
          if (fin && !on_ev && !of_ev)
          begin
            if (shrt)
              stat_r[b] <= 32'h0000_0000;
            else if (ms_r == MS_ON)
              stat_r[b][15:0] <= {tsw, tdel};
            else
              stat_r[b][31:16] <= {tsw, tdel};
            if (adapt_en && ms_r == MS_ON)
            begin
              p1_r <= hbpwm_adapt(p1_r, !(seen_r | st) || t1_r > pd, mx);
              p2_r <= hbpwm_adapt(p2_r, !dn, mx);
            end
            else if (adapt_en)
            begin
              d1_r <= hbpwm_adapt(d1_r, !(seen_r | st) || t1_r > pdd, mx);
              d2_r <= hbpwm_adapt(d2_r, !dn, mx);
            end
          end
        end
      end

      assign high_side_fet[b]      = hs_r[b];
      assign low_side_fet[b]       = ls_r[b];
      assign hold_off_active[b]    = hold_r[b];
      assign gate_current[b*6+:6]  = cur_r[b];
    end
  endgenerate

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  wire unused_ok = &{1'b0, wmerge};

endmodule : hbpwm_top

// ==== verification/hbpwm_properties.sv ====
`timescale 1ns/1ps
module hbpwm_properties
  import hbpwm_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pwm_in_a,
  input wire logic        pwm_in_e,
  input wire logic [2:0]  high_side_fet,
  input wire logic [2:0]  low_side_fet,
  input wire logic [2:0]  hold_off_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  no_shoot_a: assert property (~|(high_side_fet & low_side_fet))
    else $error("both fets of one bridge on");
  held_off_a: assert property (~|(hold_off_active & (high_side_fet | low_side_fet)))
    else $error("gate on while held off");
  dead_gap_a: assert property ($fell(high_side_fet[0]) |->
      !low_side_fet[0] ##1 !low_side_fet[0])
    else $error("no gap before low side");
  pin_a_a: assert property (high_side_fet[0] |->
      $past(pwm_in_a) || $past(pwm_in_a, 2) || $past(pwm_in_a, 3) || $past(pwm_in_a, 4))
    else $error("bridge one on without pin a");
  pin_e_a: assert property (high_side_fet[2] |->
      $past(pwm_in_e) || $past(pwm_in_e, 2) || $past(pwm_in_e, 3) || $past(pwm_in_e, 4))
    else $error("bridge three on without pin e");
  sync_off_a: assert property ($fell(pwm_in_a) && high_side_fet[0] |=>
      high_side_fet[0] ##[1:3] !high_side_fet[0])
    else $error("high side off too early or late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_pair_a: assert property (s_axi_awready |->
      s_axi_wready && s_axi_bvalid ##1 !s_axi_awready)
    else $error("write accept not paired");
  r_pair_a: assert property (s_axi_arready |-> s_axi_rvalid ##1 !s_axi_arready)
    else $error("read accept not paired");
  r_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
      s_axi_rdata == 32'h0)
    else $error("error read with data");
endmodule : hbpwm_properties

bind hbpwm_top hbpwm_properties hbpwm_properties_i (
  .clk, .srst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in_a,
  .pwm_in_e, .high_side_fet, .low_side_fet, .hold_off_active
);

// ==== verification/hbpwm_host_model.sv ====
`timescale 1ns/1ps
module hbpwm_host_model
  import hbpwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       pulse,
  input  wire logic       stall,
  input  wire logic [7:0] on_len,
  input  wire logic [7:0] off_len,
  input  wire logic [2:0] lvl,
  input  wire logic [2:0] high_side_fet,
  input  wire logic [2:0] low_side_fet,
  output logic [2:0]      pins,
  output logic [2:0]      sw_start,
  output logic [2:0]      sw_done
);
  logic [7:0] pcnt_r;
  logic [7:0] scnt_r [3];
  logic [5:0] gate_r;

  // static levels when idle, else one pwm wave on all pins
  always_ff @(posedge clk)
  begin
    if (!pulse)
    begin
      pins   <= lvl;
      pcnt_r <= 8'h00;
    end
    else if (pcnt_r + 8'h01 >= (pins[0] ? on_len : off_len))
    begin
      pins   <= {3{~pins[0]}};
      pcnt_r <= 8'h00;
    end
    else
      pcnt_r <= pcnt_r + 8'h01;
  end

  // switch node starts 3 cycles after any gate change; stall means it never settles
  always_ff @(posedge clk)
  begin
    gate_r <= {high_side_fet, low_side_fet};
    for (int b = 0; b < 3; b++)
      if (srst || {high_side_fet[b], low_side_fet[b]} != {gate_r[3+b], gate_r[b]})
        scnt_r[b] <= 8'h00;
      else if (scnt_r[b] != 8'hFF)
        scnt_r[b] <= scnt_r[b] + 8'h01;
  end

  always_comb
    for (int b = 0; b < 3; b++)
    begin
      sw_start[b] = scnt_r[b] >= 8'h02;
      sw_done[b]  = !stall && scnt_r[b] >= 8'h05;
    end
endmodule : hbpwm_host_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb
  import hbpwm_pkg::*;
();
  logic        clk, srst, pulse, stall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, on_len, off_len;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  pins, sw_start, sw_done, fet_act, hs, ls, hold, lvl;
  logic [17:0] gate_current;
  int          fail_count, checks, cycles;

  hbpwm_top hbpwm_top_i (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_in_a(pins[0]),
    .pwm_in_c(pins[1]), .pwm_in_e(pins[2]), .sw_start, .sw_done, .pwm_fet_active(fet_act),
    .high_side_fet(hs), .low_side_fet(ls), .hold_off_active(hold), .gate_current);
  hbpwm_host_model hbpwm_host_model_i (.clk, .srst, .pulse, .stall, .on_len, .off_len,
    .lvl, .high_side_fet(hs), .low_side_fet(ls), .pins, .sw_start, .sw_done);

  always #25 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  // bridges parked off before any new setting, so no shoot-through while it changes
  task automatic apply(input logic [11:0] m, input logic [2:0] p);
    wr(ADDR_MODE, 32'h0);
    lvl <= p;
    wr(ADDR_MODE, {20'h0, m});
    repeat (60) @(posedge clk);
  endtask : apply

  task automatic t_regs();
    logic [7:0]  a [5] = '{ADDR_CTRL, ADDR_MODE, ADDR_TIME0, ADDR_PCHG0, ADDR_STAT0};
    logic [31:0] e [5] = '{{27'h0, CTRL_RST}, {20'h0, MODE_RST}, {8'h0, TIME_RST},
                           {10'h0, PCHG_RST}, 32'h0};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++)
    begin
      axi_rd(a[i], d, r);
      chk("reset value", e[i], d);
    end
    axi_wr(ADDR_STAT0, 32'hFFFFFFFF, r);
    axi_rd(ADDR_STAT0, d, r);
    chk("status read only", 32'h0, d);
    axi_wr(ADDR_TIME0, 32'hFFFFFFFF, r);
    axi_rd(ADDR_TIME0, d, r);
    chk("window width", 32'h00FFFFFF, d);
    wr(ADDR_TIME0, {8'h0, TIME_RST});
    axi_wr(8'hFC, 32'h1, r);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(8'hFC, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test register_map done");
  endtask : t_regs

  task automatic t_modes();
    // entry: bridge one setting, pin, then expected high side, low side, hold off
    logic [7:0] c [9] = '{8'h48, 8'hC0, 8'h5A, 8'h50, 8'hEC, 8'hE2, 8'h60, 8'hF9, 8'hA8};
    for (int i = 0; i < 9; i++)
    begin
      apply({8'h0, c[i][7:4]}, {2'b00, c[i][3]});
      chk("bridge one gates", {29'h0, c[i][2:0]}, {29'h0, hs[0], ls[0], hold[0]});
    end
    $display("test mode_table done");
  endtask : t_modes

  task automatic t_map();
    for (int b = 0; b < 3; b++)
    begin
      apply(12'hEEE, 3'h1 << b);
      chk("pin map high", 32'h1 << b, {29'h0, hs});
      chk("pin map low", 32'h7 & ~(32'h1 << b), {29'h0, ls});
    end
    wr(ADDR_CTRL, 32'h1);
    apply(12'hEEE, 3'h7);
    chk("six input select", 32'h0, {26'h0, hs, ls});
    wr(ADDR_CTRL, 32'h0);
    $display("test pin_map done");
  endtask : t_map

  // stop only after a falling edge so the last on-time is never cut short
  task automatic run_pwm(input logic [7:0] on_c, input logic s, output logic [31:0] st);
    logic [1:0] r;
    on_len  <= on_c;
    off_len <= 8'h64;
    stall   <= s;
    pulse   <= 1'b1;
    repeat (3) @(negedge pins[0]);
    @(posedge clk);
    pulse <= 1'b0;
    repeat (60) @(posedge clk);
    axi_rd(ADDR_STAT0, st, r);
  endtask : run_pwm

  task automatic t_measure();
    logic [31:0] st;
    wr(ADDR_PCHG0, {10'h0, PCHG_RST});
    wr(ADDR_CTRL, 32'h10);
    apply(12'h00E, 3'h0);
    run_pwm(8'h64, 1'b0, st);
    chk("rise measured", 32'h1, {31'h0, |st[15:8]});
    chk("fall measured", 32'h1, {31'h0, |st[31:24]});
    chk("gate current idle", 32'h0, {14'h0, gate_current});
    run_pwm(8'h64, 1'b1, st);
    chk("rise timeout", 32'h0, {24'h0, st[15:8]});
    chk("fall timeout", 32'h0, {24'h0, st[31:24]});
    wr(ADDR_CTRL, 32'h2);
    fet_act <= 3'h0;
    run_pwm(8'h04, 1'b0, st);
    chk("short pulse status", 32'h0, st);
    chk("short pulse freewheel", 32'h0, {31'h0, ls[0]});
    $display("test measurement done");
  endtask : t_measure

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {clk, pulse, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, lvl} = 21'h0;
    {s_axi_wdata, on_len, off_len} = 48'h0;
    fet_act    = 3'h7;
    srst       = 1'b1;
    fail_count = 0;
    checks     = 0;
    cycles     = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_modes();
    t_map();
    t_measure();
    tally_and_finish();
  end
endmodule : tb
